/* File: ppfd_gpio.sv */
`timescale 1ns/1ns
module ppfd_gpio #(
  parameter logic [31:0] PIN_PRESENT = 32'hFFFFFFFF, // per pin: 1 when bonded out
  parameter logic [31:0] SINK_CODE   = 32'h00000000  // 2 bits per port: pair picking sink
) (
  input  wire logic        sys_clk,      // 250 MHz system clock
  input  wire logic        rst_n,        // async reset, active low
  input  wire logic [11:0] reg_addr,     // register byte address
  input  wire logic [7:0]  reg_wdata,    // write data
  input  wire logic        reg_wr,       // write strobe
  input  wire logic        reg_rd,       // read strobe
  output logic      [7:0]  reg_rdata,    // read data, cycle after strobe
  input  wire logic [31:0] pin_in,       // pin levels, port a in low byte
  output logic      [31:0] pin_out,      // pin output value
  output logic      [31:0] pin_oe,       // pin output enable, high drives
  input  wire logic [31:0] periph_out,   // peripheral output value per pin
  input  wire logic [31:0] periph_oe,    // peripheral wants to drive per pin
  output logic      [31:0] periph_sel,   // set one bit of the function code per pin (a..d order)
  output logic      [31:0] periph_active,// pin handed to its peripheral
  output logic      [7:0]  sink_on       // current sink connected on port c pin
);
  import ppfd_pkg::*;

  logic        rst_s1_ff, rst_s2_ff;
  logic        srst_n;
  logic [31:0] sync_level;

  // release reset through two flops so every flop leaves reset together
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign srst_n = rst_s2_ff;

  // per-port pin samplers
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_sync
      ppfd_sync u_sync (
        .sys_clk (sys_clk),
        .rst_n   (srst_n),
        .pin_in  (pin_in[gp*8 +: 8]),
        .level   (sync_level[gp*8 +: 8])
      );
    end
  endgenerate

  // register state
  logic [7:0] index_ff      [NUM_PORTS];
  logic [7:0] dir_ff        [NUM_PORTS];
  logic [7:0] takeover_ff   [NUM_PORTS];
  logic [7:0] open_drain_ff [NUM_PORTS];
  logic [7:0] sel_first_ff  [NUM_PORTS];
  logic [7:0] sel_second_ff [NUM_PORTS];
  logic [7:0] out_value_ff  [NUM_PORTS];
  logic [7:0] sink_en_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_index      [NUM_PORTS];
  logic [7:0] nxt_dir        [NUM_PORTS];
  logic [7:0] nxt_takeover   [NUM_PORTS];
  logic [7:0] nxt_open_drain [NUM_PORTS];
  logic [7:0] nxt_sel_first  [NUM_PORTS];
  logic [7:0] nxt_sel_second [NUM_PORTS];
  logic [7:0] nxt_out_value  [NUM_PORTS];
  logic [7:0] nxt_sink_en;
  logic [7:0] nxt_rdata;
  logic [7:0] in_masked      [NUM_PORTS];

  // absent pins always read zero
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      in_masked[p] = sync_level[p*8 +: 8] & PIN_PRESENT[p*8 +: 8];
    end
  end

  // register writes; input registers have no write path
  always_comb begin
    logic [11:0] base;
    base = 12'h000;
    nxt_sink_en = sink_en_ff;
    if (reg_wr && reg_addr == ADDR_SINK_EN) begin
      nxt_sink_en = reg_wdata;
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      base              = ADDR_A_INDEX + PORT_STRIDE * 12'(p);
      nxt_index[p]      = index_ff[p];
      nxt_dir[p]        = dir_ff[p];
      nxt_takeover[p]   = takeover_ff[p];
      nxt_open_drain[p] = open_drain_ff[p];
      nxt_sel_first[p]  = sel_first_ff[p];
      nxt_sel_second[p] = sel_second_ff[p];
      nxt_out_value[p]  = out_value_ff[p];
      if (reg_wr && reg_addr == base) begin
        nxt_index[p] = reg_wdata;
      end
      if (reg_wr && reg_addr == base + 12'h001) begin
        unique case (index_ff[p])
          SUB_DIR:        nxt_dir[p]        = reg_wdata;
          SUB_TAKEOVER:   nxt_takeover[p]   = reg_wdata;
          SUB_OPEN_DRAIN: nxt_open_drain[p] = reg_wdata;
          SUB_SEL_FIRST:  nxt_sel_first[p]  = reg_wdata;
          SUB_SEL_SECOND: nxt_sel_second[p] = reg_wdata;
          default:        ;
        endcase
      end
      if (reg_wr && reg_addr == base + 12'h003) begin
        nxt_out_value[p] = reg_wdata;
      end
    end
  end

  // read mux; unmapped addresses and unimplemented subregisters read zero
  always_comb begin
    logic [11:0] base;
    base      = 12'h000;
    nxt_rdata = RST_ZERO;
    if (reg_rd) begin
      if (reg_addr == ADDR_SINK_EN) begin
        nxt_rdata = sink_en_ff;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        base = ADDR_A_INDEX + PORT_STRIDE * 12'(p);
        if (reg_addr == base) begin
          nxt_rdata = index_ff[p];
        end
        if (reg_addr == base + 12'h001) begin
          unique case (index_ff[p])
            SUB_DIR:        nxt_rdata = dir_ff[p];
            SUB_TAKEOVER:   nxt_rdata = takeover_ff[p];
            SUB_OPEN_DRAIN: nxt_rdata = open_drain_ff[p];
            SUB_SEL_FIRST:  nxt_rdata = sel_first_ff[p];
            SUB_SEL_SECOND: nxt_rdata = sel_second_ff[p];
            default:        nxt_rdata = RST_ZERO;
          endcase
        end
        if (reg_addr == base + 12'h002) begin
          nxt_rdata = in_masked[p];
        end
        if (reg_addr == base + 12'h003) begin
          nxt_rdata = out_value_ff[p];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        index_ff[p]      <= RST_ZERO;
        dir_ff[p]        <= RST_DIR;
        takeover_ff[p]   <= (p == NUM_PORTS - 1) ? RST_TAKEOVER_D : RST_ZERO;
        open_drain_ff[p] <= RST_ZERO;
        sel_first_ff[p]  <= RST_ZERO;
        sel_second_ff[p] <= RST_ZERO;
        out_value_ff[p]  <= RST_ZERO;
      end
      sink_en_ff <= RST_ZERO;
      rdata_ff   <= RST_ZERO;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        index_ff[p]      <= nxt_index[p];
        dir_ff[p]        <= nxt_dir[p];
        takeover_ff[p]   <= nxt_takeover[p];
        open_drain_ff[p] <= nxt_open_drain[p];
        sel_first_ff[p]  <= nxt_sel_first[p];
        sel_second_ff[p] <= nxt_sel_second[p];
        out_value_ff[p]  <= nxt_out_value[p];
      end
      sink_en_ff <= nxt_sink_en;
      rdata_ff   <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // pad control per pin; direction bit 1 means input, so 0 drives
  genvar gq, gb;
  generate
    for (gq = 0; gq < NUM_PORTS; gq++) begin : g_port
      for (gb = 0; gb < PORT_PINS; gb++) begin : g_pin
        localparam int N = gq * 8 + gb;
        logic       take;
        logic       drv_val;
        logic       drv_en;
        logic [1:0] code;
        assign code = {sel_second_ff[gq][gb], sel_first_ff[gq][gb]};
        assign take = takeover_ff[gq][gb];
        // set-one bit is always visible; the peripheral owns the pin only via takeover
        assign periph_sel[gq*8 + gb]  = code[0];
        assign periph_active[N]       = take;
        assign drv_val = take ? periph_out[N] : out_value_ff[gq][gb];
        assign drv_en  = take ? periph_oe[N] : ~dir_ff[gq][gb];
        assign pin_out[N] = drv_val;
        // open drain drops the high side in any mode
        assign pin_oe[N]  = drv_en & ~(drv_val & open_drain_ff[gq][gb]);
      end
    end
  endgenerate

  // sink on port c; gated by the enable bit, by takeover and by the pin's pair matching SINK_CODE
  generate
    for (gb = 0; gb < PORT_PINS; gb++) begin : g_sink
      assign sink_on[gb] = sink_en_ff[gb] & takeover_ff[PORT_C][gb]
                         & ({sel_second_ff[PORT_C][gb], sel_first_ff[PORT_C][gb]}
                            == SINK_CODE[PORT_C*2 +: 2]);
    end
  endgenerate
endmodule // ppfd_gpio

/* File: ppfd_pkg.sv */
package ppfd_pkg;
  // register offsets (byte addresses on the 12-bit register port)
  localparam logic [11:0] ADDR_SINK_EN   = 12'hF82;
  localparam logic [11:0] ADDR_A_IN      = 12'hFD2;
  localparam logic [11:0] ADDR_B_IN      = 12'hFD6;
  localparam logic [11:0] ADDR_C_IN      = 12'hFDA;
  localparam logic [11:0] ADDR_D_IN      = 12'hFDE;
  localparam logic [11:0] ADDR_A_OUT     = 12'hFD3;
  localparam logic [11:0] ADDR_B_OUT     = 12'hFD7;
  localparam logic [11:0] ADDR_C_OUT     = 12'hFDB;
  localparam logic [11:0] ADDR_D_OUT     = 12'hFDF;
  localparam logic [11:0] ADDR_A_INDEX   = 12'hFD0;
  localparam logic [11:0] ADDR_A_CTRL    = 12'hFD1;
  localparam logic [11:0] PORT_STRIDE    = 12'h004;
  // subregister indices behind each port's control register
  localparam logic [7:0]  SUB_DIR        = 8'h01;
  localparam logic [7:0]  SUB_TAKEOVER   = 8'h02;
  localparam logic [7:0]  SUB_OPEN_DRAIN = 8'h03;
  localparam logic [7:0]  SUB_SEL_FIRST  = 8'h07;
  localparam logic [7:0]  SUB_SEL_SECOND = 8'h08;
  // reset values
  localparam logic [7:0]  RST_ZERO       = 8'h00;
  localparam logic [7:0]  RST_DIR        = 8'hFF;
  localparam logic [7:0]  RST_TAKEOVER_D = 8'h01;
  localparam int          NUM_PORTS      = 4;
  localparam int          PORT_PINS      = 8;
  localparam int          PORT_C         = 2;
endpackage

/* File: ppfd_sync.sv */
`timescale 1ns/1ns
// three-stage pin sampler; a change is accepted once stages two and three agree
module ppfd_sync (
  input  wire logic       sys_clk,  // system clock
  input  wire logic       rst_n,    // synchronised reset, active low
  input  wire logic [7:0] pin_in,   // raw pin levels
  output logic      [7:0] level     // filtered level
);
  import ppfd_pkg::*;
  logic [7:0] s1_ff, s2_ff, s3_ff, level_ff, nxt_level;

  // accept only when the two settled stages agree
  always_comb begin
    for (int i = 0; i < PORT_PINS; i++) begin
      nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff    <= RST_ZERO;
      s2_ff    <= RST_ZERO;
      s3_ff    <= RST_ZERO;
      level_ff <= RST_ZERO;
    end else begin
      s1_ff    <= pin_in;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;
endmodule // ppfd_sync

/* File: ppfd_gpio_checker.sv */
`timescale 1ns/1ns
// port-level watch on register walks and pin drive of ppfd_gpio
module ppfd_chk import ppfd_pkg::*; #(
  parameter logic [31:0] PIN_PRESENT = 32'hFFFFFFFF // bonded pins
) (
  input wire logic        sys_clk,       // clock
  input wire logic        rst_n,         // reset
  input wire logic [11:0] reg_addr,      // address
  input wire logic [7:0]  reg_wdata,     // write data
  input wire logic        reg_wr,        // write
  input wire logic        reg_rd,        // read
  input wire logic [7:0]  reg_rdata,     // read data
  input wire logic [31:0] pin_in,        // pins
  input wire logic [31:0] pin_out,       // drive value
  input wire logic [31:0] pin_oe,        // drive enable
  input wire logic [31:0] periph_out,    // peripheral value
  input wire logic [31:0] periph_oe,     // peripheral enable
  input wire logic [31:0] periph_sel,    // set one bits
  input wire logic [31:0] periph_active, // takeover
  input wire logic [7:0]  sink_on        // sink
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // index write, control write, control read in consecutive cycles
  sequence s_idx(logic [7:0] v); reg_wr && reg_addr == ADDR_A_INDEX && reg_wdata == v; endsequence
  sequence s_cw; reg_wr && reg_addr == ADDR_A_CTRL; endsequence
  sequence s_cr; reg_rd && reg_addr == ADDR_A_CTRL; endsequence
  // the pin sampler lags, so a read is predictable only after quiet pins
  sequence s_quiet; $stable(pin_in) [*6]; endsequence
  property p_sel1; s_idx(SUB_SEL_FIRST) ##1 s_cw ##1 s_cr |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_sel1: assert property (p_sel1) else $error("set one readback wrong");
  property p_sel2; s_idx(SUB_SEL_SECOND) ##1 s_cw ##1 s_cr |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_sel2: assert property (p_sel2) else $error("set two readback wrong");
  property p_selpin; s_idx(SUB_SEL_FIRST) ##1 s_cw |=> periph_sel[7:0] == $past(reg_wdata); endproperty
  a_selpin: assert property (p_selpin) else $error("set one not on pins");
  property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer cycle");
  property p_in; s_quiet ##0 (reg_rd && reg_addr == ADDR_A_IN) |=> reg_rdata == ($past(pin_in[7:0]) & PIN_PRESENT[7:0]); endproperty
  a_in: assert property (p_in) else $error("input sample wrong");
  property p_out; reg_wr && reg_addr == ADDR_A_OUT |=> ((pin_out[7:0] ^ $past(reg_wdata)) & pin_oe[7:0] & ~periph_active[7:0]) == 8'h00; endproperty
  a_out: assert property (p_out) else $error("output value not driven");
  property p_take; (pin_oe & periph_active & ((pin_out ^ periph_out) | ~periph_oe)) == 32'h0; endproperty
  a_take: assert property (p_take) else $error("taken pin not under peripheral");
  property p_sink; (sink_on & ~periph_active[23:16]) == 8'h00; endproperty
  a_sink: assert property (p_sink) else $error("sink without takeover");
endmodule // ppfd_chk
bind ppfd_gpio ppfd_chk #(.PIN_PRESENT(PIN_PRESENT)) i_ppfd_chk (.sys_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe, .periph_out,
  .periph_oe, .periph_sel, .periph_active, .sink_on);

/* File: ppfd_board.sv */
`timescale 1ns/1ns
// board side: undriven pins sit at resistor levels; a sink pulls a free port c pin low
module ppfd_board (
  input  wire logic [31:0] pin_out,   // device value
  input  wire logic [31:0] pin_oe,    // device drives
  input  wire logic [7:0]  sink_on,   // sink connected
  input  wire logic [31:0] ext_level, // resistor levels
  output logic      [31:0] pin_in     // pin level
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level & ~{8'h00, sink_on, 16'h0000});
endmodule // ppfd_board

/* File: port_pin_function_and_data_test.sv */
`timescale 1ns/1ns
module port_pin_function_and_data_test;
  import ppfd_pkg::*;
  localparam logic [31:0] PRES = 32'hFFFFFF3F; // port a pins 6, 7 lost to analog inputs
  localparam logic [31:0] SINK = 32'h00000010; // port c pair 01 picks the sink
  logic        sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000, pp;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, sink_on, m_sk = 8'h00, e_sk, ix, d;
  logic [31:0] pin_in, pin_out, pin_oe, periph_sel, periph_active, e_v, e_oe, e_in;
  logic [31:0] periph_out = 32'h0, periph_oe = 32'h0, ext_level = 32'h0;
  logic [31:0] m_out = 32'h0, m_dir = 32'hFFFFFFFF, m_od = 32'h0, m_s1 = 32'h0, m_s2 = 32'h0;
  logic [31:0] m_af = 32'h01000000; // port d pin 0 starts handed over
  integer      seed = 32'hD2EA6B6E, n_errors = 0, n_tests = 0, k;
  ppfd_gpio #(.PIN_PRESENT(PRES), .SINK_CODE(SINK)) i_ppfd_gpio (.sys_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe, .periph_out,
    .periph_oe, .periph_sel, .periph_active, .sink_on);
  ppfd_board i_ppfd_board (.pin_out, .pin_oe, .sink_on, .ext_level, .pin_in);
  initial forever #2 sys_clk = ~sys_clk;
  function logic [7:0] rnd;
    rnd = 8'($random(seed));
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle; strobes stay up across back-to-back calls
  task op(input logic w, input logic r, input logic [11:0] a, input logic [7:0] v);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] v);
    op(1'b1, 1'b0, a, v);
    if (a == ADDR_SINK_EN) m_sk = v;
    if (a[11:4] == 8'hFD && a[1:0] == 2'b11) m_out[8 * a[3:2] +: 8] = v;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    op(1'b0, 1'b1, a, 8'h00);
    #1 chk({24'h0, reg_rdata}, {24'h0, e});
  endtask
  // subregister write through index then control, mirrored in the bench copy
  task wsub(input logic [11:0] p, input logic [7:0] i, input logic [7:0] v);
    wr(ADDR_A_INDEX + PORT_STRIDE * p, i);
    wr(ADDR_A_CTRL + PORT_STRIDE * p, v);
    case (i)
      SUB_DIR: m_dir[8 * p +: 8] = v;
      SUB_TAKEOVER: m_af[8 * p +: 8] = v;
      SUB_OPEN_DRAIN: m_od[8 * p +: 8] = v;
      SUB_SEL_FIRST: m_s1[8 * p +: 8] = v;
      default: m_s2[8 * p +: 8] = v;
    endcase
  endtask
  // pins and input samples predicted from the bench copy; sink needs pair 01
  task chk_pins;
    repeat (6) op(1'b0, 1'b0, 12'h000, 8'h00);
    #1; // look at pad outputs once the edge has settled, not in its own time step
    e_v = (m_af & periph_out) | (~m_af & m_out);
    e_oe = ((m_af & periph_oe) | (~m_af & ~m_dir)) & ~(e_v & m_od);
    e_sk = m_sk & m_af[23:16] & m_s1[23:16] & ~m_s2[23:16];
    e_in = ((e_oe & e_v) | (~e_oe & ext_level & ~{8'h00, e_sk, 16'h0000})) & PRES;
    chk(pin_oe, e_oe);
    chk(pin_out & e_oe, e_v & e_oe);
    chk(periph_active, m_af);
    chk(periph_sel, m_s1);
    chk({24'h0, sink_on}, {24'h0, e_sk});
    for (pp = 0; pp < 4; pp++) rd(ADDR_A_IN + PORT_STRIDE * pp, e_in[8 * pp +: 8]);
    for (pp = 0; pp < 4; pp++) rd(ADDR_A_OUT + PORT_STRIDE * pp, m_out[8 * pp +: 8]);
  endtask
  task end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard far beyond the roughly 1200 cycles the run takes
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ext_level <= {rnd(), rnd(), rnd(), rnd()};
    rd(ADDR_SINK_EN, 8'h00);
    rd(12'h123, 8'h00);
    chk_pins;
    for (pp = 0; pp < 4; pp++) begin
      for (k = 0; k < 2; k++) begin
        ix = k ? SUB_SEL_SECOND : SUB_SEL_FIRST;
        wr(ADDR_A_INDEX + PORT_STRIDE * pp, ix);
        rd(ADDR_A_CTRL + PORT_STRIDE * pp, 8'h00);
        d = rnd();
        wsub(pp, ix, d);
        rd(ADDR_A_CTRL + PORT_STRIDE * pp, d);
      end
      rd(ADDR_A_OUT + PORT_STRIDE * pp, 8'h00);
    end
    $display("selection test done");
    wsub(12'h002, SUB_SEL_FIRST, 8'hFF);
    wsub(12'h002, SUB_SEL_SECOND, 8'h00);
    wsub(12'h002, SUB_TAKEOVER, 8'hFF);
    wr(ADDR_SINK_EN, 8'hA5);
    rd(ADDR_SINK_EN, 8'hA5);
    chk_pins;
    $display("sink test done");
    for (k = 0; k < 40; k++) begin
      d = rnd();
      pp = {10'h000, d[1:0]};
      wsub(pp, SUB_DIR, rnd());
      wsub(pp, SUB_TAKEOVER, rnd());
      wsub(pp, SUB_OPEN_DRAIN, rnd());
      wsub(pp, SUB_SEL_FIRST, rnd());
      wsub(pp, SUB_SEL_SECOND, rnd());
      wr(ADDR_A_OUT + PORT_STRIDE * pp, rnd());
      wr(ADDR_A_IN + PORT_STRIDE * pp, rnd());
      wr(ADDR_SINK_EN, rnd());
      periph_out <= {rnd(), rnd(), rnd(), rnd()};
      periph_oe <= {rnd(), rnd(), rnd(), rnd()};
      ext_level <= {rnd(), rnd(), rnd(), rnd()};
      chk_pins;
    end
    $display("random drive test done");
    end_sim;
  end
endmodule // port_pin_function_and_data_test
